// ### include/tcdma_map.svh
// Constants for the two channel transfer engine.
// Assumes inclusion by the package, the design file and the testbench.
`ifndef TCDMA_MAP_SVH
`define TCDMA_MAP_SVH
`define TCDMA_CHANNELS 2
`define TCDMA_ADDR_W 20
`define TCDMA_COUNT_W 16
`define TCDMA_REQ_DELAY 4
`define TCDMA_SRC_PIN 2'h0
`define TCDMA_SRC_TIMER 2'h1
`define TCDMA_SRC_SOFT 2'h2
`define TCDMA_STEP_KEEP 2'h0
`define TCDMA_STEP_INC 2'h1
`define TCDMA_STEP_DEC 2'h2
`endif

// ### include/tcdma_pkg.sv
// Types for the two channel transfer engine.
// Assumes tcdma_map.svh is on the include path.
`include "tcdma_map.svh"
package tcdma_pkg;
	typedef struct packed {
		logic armed;
		logic [1:0] req_src;
		logic dest_sync;
		logic word;
		logic src_io;
		logic dst_io;
		logic [1:0] src_step;
		logic [1:0] dst_step;
		logic stop_at_zero;
		logic [`TCDMA_ADDR_W-1:0] src_ptr;
		logic [`TCDMA_ADDR_W-1:0] dst_ptr;
		logic [`TCDMA_COUNT_W-1:0] count;
	} tcdma_cfg_s;
	typedef struct packed {
		logic write;
		logic io;
		logic word;
		logic [`TCDMA_ADDR_W-1:0] addr;
		logic [15:0] wdata;
	} tcdma_cyc_s;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FETCH = 3'b001,
		ST_FETCH_HI = 3'b010,
		ST_DEPOSIT = 3'b011,
		ST_DEPOSIT_HI = 3'b100,
		ST_DONE = 3'b101
	} tcdma_state_e;
endpackage

// ### verification/tcdma_bus_model.sv
// Behavioural bus cycle engine with a byte-wide memory behind it.
// Assumes the engine sees one cycle at a time and answers with done.
`timescale 1ns/1ps
module tcdma_bus_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic valid,
	output logic ready,
	input wire tcdma_pkg::tcdma_cyc_s cyc,
	output logic done,
	output logic [15:0] rdata
);
	import tcdma_pkg::*;
	tcdma_cyc_s held;
	logic [31:0] rnd = 32'h1;
	int wait_n = -1;
	int n_cyc = 0;
	logic [28:0] wlog[$];
	function automatic logic [7:0] bt(input logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ 8'ha5;
	endfunction
	// Ready and latency wander so both prompt and slow answers occur.
	always @(posedge clk) begin
		rnd <= {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
		done <= 1'b0;
		rdata <= ~rdata;
		if (!rst_n) begin
			ready <= 1'b0;
			wait_n <= -1;
			rdata <= 16'h0;
		end else if (valid && ready) begin
			held <= cyc;
			ready <= 1'b0;
			wait_n <= int'(rnd[1:0]);
			n_cyc <= n_cyc + 1;
		end else if (wait_n == 0) begin
			done <= 1'b1;
			wait_n <= -1;
			rdata <= {bt(held.addr | 20'h1), bt(held.addr & 20'hffffe)};
			if (held.write && held.word && !held.addr[0]) begin
				wlog.push_back({held.io, held.addr, held.wdata[7:0]});
				wlog.push_back({held.io, held.addr + 20'h1, held.wdata[15:8]});
			end else if (held.write) begin
				wlog.push_back({held.io, held.addr,
					held.addr[0] ? held.wdata[15:8] : held.wdata[7:0]});
			end
		end else if (wait_n > 0) begin
			wait_n <= wait_n - 1;
		end else begin
			ready <= rnd[2] | rnd[3];
		end
	end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the two channel transfer engine.
// Assumes the package and the bus model are compiled before it.
`timescale 1ns/1ps
`include "tcdma_map.svh"
module testbench;
	import tcdma_pkg::*;
	logic clk = 0;
	logic rst_n = 0;
	tcdma_cfg_s cfg0 = '0;
	tcdma_cfg_s cfg1 = '0;
	logic [1:0] load = 2'h0;
	localparam int BUS_W = 16;
	logic [1:0] req = 2'h0;
	logic [1:0] susp = 2'h0;
	logic tick = 0;
	logic cyc_valid, cyc_ready, cyc_done;
	tcdma_cyc_s cyc;
	logic [15:0] rdata;
	logic [1:0] armed, busy;
	logic [31:0] counts;
	logic [31:0] lf = 32'h90063444;
	int n_fail = 0;
	int cmp_count = 0;
	always #5 clk = ~clk;
	tcdma_top #(.BUS_W(BUS_W)) dut_u (.REF_CLK(clk), .RST_N(rst_n),
		.CFG0(cfg0), .CFG1(cfg1), .LOAD(load), .SUSPEND(susp),
		.XFER_REQ(req), .TIMER_TICK(tick), .CYC_VALID(cyc_valid),
		.CYC_READY(cyc_ready), .CYC(cyc), .CYC_DONE(cyc_done),
		.CYC_RDATA(rdata), .ARMED(armed), .CH_BUSY(busy),
		.COUNTS(counts));
	tcdma_bus_model bm_u (.clk(clk), .rst_n(rst_n), .valid(cyc_valid),
		.ready(cyc_ready), .cyc(cyc), .done(cyc_done), .rdata(rdata));
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [7:0] bt(input logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ 8'ha5;
	endfunction
	function automatic logic [19:0] mv(input logic [19:0] p,
		input logic [1:0] m, input int w);
		if (m == `TCDMA_STEP_INC) return p + 20'(w);
		if (m == `TCDMA_STEP_DEC) return p - 20'(w);
		return p;
	endfunction
	task automatic step();
		@(posedge clk);
		#1;
		lf = nxt(lf);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			n_fail++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One whole programmed block per call; the channel alternates.
	task automatic run(input int t);
		tcdma_cfg_s c;
		logic [28:0] exp[$];
		logic [19:0] s, d;
		int w, n0, ncy, i, ch;
		ch = t % 2;
		c = {lf, nxt(lf), lf[3:0]};
		c.armed = 1'b1;
		c.stop_at_zero = 1'b1;
		c.req_src = 2'(lf[5:0] % 3);
		c.count = 16'(1 + lf[9:8]);
		if (c.src_step == 2'h3) c.src_step = `TCDMA_STEP_KEEP;
		if (c.dst_step == 2'h3) c.dst_step = `TCDMA_STEP_DEC;
		if (t == 0) begin
			c.word = 1'b1;
			c.src_ptr = 20'hfffff;
			c.src_step = `TCDMA_STEP_INC;
			c.req_src = `TCDMA_SRC_SOFT;
		end
		if (t == 1) c.req_src = `TCDMA_SRC_PIN;
		if (BUS_W == 8) c.word = 1'b0;
		w = c.word ? 2 : 1;
		s = c.src_ptr;
		d = c.dst_ptr;
		for (int k = 0; k < int'(c.count); k++) begin
			for (int j = 0; j < w; j++)
				exp.push_back({c.dst_io, d + 20'(j), bt(s + 20'(j))});
			s = mv(s, c.src_step, w);
			d = mv(d, c.dst_step, w);
		end
		ncy = int'(c.count) * (((c.word & c.src_ptr[0]) ? 2 : 1)
			+ ((c.word & c.dst_ptr[0]) ? 2 : 1));
		n0 = bm_u.n_cyc;
		bm_u.wlog.delete();
		if (ch == 1) cfg1 = c;
		else cfg0 = c;
		load[ch] = 1'b1;
		step();
		load[ch] = 1'b0;
		if (c.req_src == `TCDMA_SRC_PIN) begin
			req[ch] = 1'b1;
			for (i = 0; i < 100 && cyc_valid !== 1'b1; i++) step();
			check(32'(i >= 4 && i < 100), 32'h1);
		end
		for (i = 0; i < 3000; i++) begin
			if (armed[ch] === 1'b0 && busy[ch] === 1'b0) break;
			tick = (c.req_src == `TCDMA_SRC_TIMER) && (i % 50 == 10);
			susp[ch] = i % 16 < 3;
			step();
		end
		tick = 1'b0;
		susp[ch] = 1'b0;
		req[ch] = 1'b0;
		if (i == 3000) begin
			n_fail++;
			tally_and_finish();
		end
		check(32'(bm_u.wlog.size()), 32'(exp.size()));
		for (i = 0; i < exp.size() && i < bm_u.wlog.size(); i++)
			check(32'(bm_u.wlog[i]), 32'(exp[i]));
		check(32'(bm_u.n_cyc - n0), 32'(ncy));
		check(32'(ch ? counts[31:16] : counts[15:0]), 32'h0);
		$display("test %0d ch %0d src %0d done", t, ch, c.req_src);
	endtask
	// Word transfers are always legal here, as the bus is 16 bits wide.
	initial begin
		repeat (6) step();
		rst_n = 1'b1;
		for (int t = 0; t < 10; t++) run(t);
		tally_and_finish();
	end
endmodule

// ### verilog/tcdma_top.sv
// Two channel transfer engine driving the bus cycle engine.
// Assumes the bus cycle engine answers each cycle with a one cycle done.
//
// What this block does
// - Two identical, independent channels.
// - Request source: pin, timer or software.
// - Full memory and I/O reach, bytes or words.
// - Transfer starts on source, destination or software.
// - Engine makes bus signals; channel gives addresses.
// - No acknowledge output toward the peripheral.
// - Run while request active; zero count stops it only if stop_at_zero is set or the source is software.
// - Fetch into holding register, then deposit.
// - Fetch and deposit never split by others.
// - Source and destination space chosen separately.
// - Peripheral register space reachable like any address.
// - Byte or word per channel, bus-width handling.
// - Odd word on a 16-bit bus: two fetches from an odd source, two deposits to an odd destination.
// - 20-bit pointers step up, down or hold.
// - 16-bit count drops per transfer; optional stop.
// - Request pins sampled; start four clocks later.
`timescale 1ns/1ps
`include "tcdma_map.svh"
module tcdma_top #(
	parameter int BUS_W = 16
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire tcdma_pkg::tcdma_cfg_s CFG0,
	input wire tcdma_pkg::tcdma_cfg_s CFG1,
	input wire logic [1:0] LOAD,
	input wire logic [1:0] SUSPEND,
	input wire logic [1:0] XFER_REQ,
	input wire logic TIMER_TICK,
	output logic CYC_VALID,
	input wire logic CYC_READY,
	output tcdma_pkg::tcdma_cyc_s CYC,
	input wire logic CYC_DONE,
	input wire logic [15:0] CYC_RDATA,
	output logic [1:0] ARMED,
	output logic [1:0] CH_BUSY,
	output logic [31:0] COUNTS
);
	import tcdma_pkg::*;

	if (BUS_W != 8 && BUS_W != 16) begin : g_bad_bus_w
		$error("BUS_W must be 8 or 16.");
	end

	tcdma_cfg_s cfg [2];
	logic [1:0] req_q;
	logic [2:0] req_age [2];
	logic [1:0] tick_pend;
	tcdma_state_e state;
	logic ch;
	logic [15:0] hold;
	logic [1:0] idle_wait;
	logic [1:0] want;
	logic [1:0] buf_v;
	tcdma_cyc_s buf_d [2];
	logic push;
	tcdma_cyc_s push_d;
	logic split;
	logic src_hi, dst_hi;

	function automatic logic [`TCDMA_ADDR_W-1:0] step_ptr(
		input logic [`TCDMA_ADDR_W-1:0] p, input logic [1:0] mode,
		input logic word);
		logic [`TCDMA_ADDR_W-1:0] d;
		d = word ? `TCDMA_ADDR_W'(2) : `TCDMA_ADDR_W'(1);
		if (mode == `TCDMA_STEP_INC)
			return p + d;
		else if (mode == `TCDMA_STEP_DEC)
			return p - d;
		return p;
	endfunction

	// Request pins are registered once, standing in for the clock sample.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N)
			req_q <= 2'h0;
		else
			req_q <= XFER_REQ;
	end

	// A request must have been seen four clocks before it may start.
	always_ff @(posedge REF_CLK) begin
		for (int i = 0; i < 2; i++) begin
			if (!RST_N)
				req_age[i] <= 3'h0;
			else if (!req_q[i])
				req_age[i] <= 3'h0;
			else if (req_age[i] != 3'(`TCDMA_REQ_DELAY))
				req_age[i] <= req_age[i] + 3'h1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		for (int i = 0; i < 2; i++) begin
			if (!RST_N)
				tick_pend[i] <= 1'b0;
			else if (TIMER_TICK)
				tick_pend[i] <= 1'b1;
			else if (LOAD[i])
				tick_pend[i] <= 1'b0;
			else if (state == ST_DONE && ch == 1'(i))
				tick_pend[i] <= 1'b0;
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			unique case (cfg[i].req_src)
			`TCDMA_SRC_PIN:
				want[i] = req_age[i] == 3'(`TCDMA_REQ_DELAY);
			`TCDMA_SRC_TIMER:
				want[i] = tick_pend[i];
			default:
				want[i] = 1'b1;
			endcase
			want[i] = want[i] && cfg[i].armed && !SUSPEND[i];
		end
	end

	// Odd words on a wide bus take two cycles in each phase whose pointer is odd.
	assign split = cfg[ch].word && BUS_W == 16;
	assign src_hi = BUS_W == 16 && cfg[ch].src_ptr[0];
	assign dst_hi = BUS_W == 16 && cfg[ch].dst_ptr[0];

	// Sequencer; one channel owns the engine from fetch to deposit.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			state <= ST_IDLE;
			ch <= 1'b0;
			idle_wait <= 2'h0;
		end else begin
			unique case (state)
			ST_IDLE:
				if (idle_wait != 2'h0)
					idle_wait <= idle_wait - 2'h1;
				else if (want[0] || want[1]) begin
					// Fixed order favours channel 0 when both ask.
					ch <= want[0] ? 1'b0 : 1'b1;
					state <= ST_FETCH;
				end
			ST_FETCH:
				if (CYC_DONE)
					state <= (split && cfg[ch].src_ptr[0]) ?
						ST_FETCH_HI : ST_DEPOSIT;
			ST_FETCH_HI:
				if (CYC_DONE)
					state <= ST_DEPOSIT;
			ST_DEPOSIT:
				if (CYC_DONE)
					state <= (split && cfg[ch].dst_ptr[0]) ?
						ST_DEPOSIT_HI : ST_DONE;
			ST_DEPOSIT_HI:
				if (CYC_DONE)
					state <= ST_DONE;
			ST_DONE: begin
				state <= ST_IDLE;
				// Three idle states let a destination drop its request.
				idle_wait <= cfg[ch].dest_sync ? 2'h2 : 2'h0;
			end
			default:
				state <= ST_IDLE;
			endcase
		end
	end

	// Holding register between fetch and deposit.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N)
			hold <= 16'h0000;
		else if (CYC_DONE && state == ST_FETCH)
			hold <= src_hi ?
				{8'h00, CYC_RDATA[15:8]} : CYC_RDATA;
		else if (CYC_DONE && state == ST_FETCH_HI)
			hold <= {CYC_RDATA[7:0], hold[7:0]};
	end

	// Channel state: pointers, count and arming.
	always_ff @(posedge REF_CLK) begin
		for (int i = 0; i < 2; i++) begin
			if (!RST_N)
				cfg[i] <= '0;
			else if (LOAD[i])
				cfg[i] <= i == 0 ? CFG0 : CFG1;
			else if (state == ST_DONE && ch == 1'(i)) begin
				cfg[i].src_ptr <= step_ptr(cfg[i].src_ptr,
					cfg[i].src_step, cfg[i].word);
				cfg[i].dst_ptr <= step_ptr(cfg[i].dst_ptr,
					cfg[i].dst_step, cfg[i].word);
				cfg[i].count <= cfg[i].count - 16'h0001;
				if (cfg[i].count == 16'h0001 && (cfg[i].stop_at_zero ||
						cfg[i].req_src == `TCDMA_SRC_SOFT))
					cfg[i].armed <= 1'b0;
			end
		end
	end

	// Cycle request for the current phase; space bits pass untouched.
	always_comb begin
		push_d = '0;
		if (state == ST_FETCH || state == ST_FETCH_HI) begin
			push_d.word = cfg[ch].word && !src_hi;
			push_d.io = cfg[ch].src_io;
			push_d.addr = cfg[ch].src_ptr +
				(state == ST_FETCH_HI ? `TCDMA_ADDR_W'(1) : '0);
		end else begin
			push_d.word = cfg[ch].word && !dst_hi;
			push_d.write = 1'b1;
			push_d.io = cfg[ch].dst_io;
			push_d.addr = cfg[ch].dst_ptr +
				(state == ST_DEPOSIT_HI ? `TCDMA_ADDR_W'(1) : '0);
			push_d.wdata = state == ST_DEPOSIT_HI ? {8'h00, hold[15:8]} :
				dst_hi ? {hold[7:0], 8'h00} : hold;
		end
	end

	// One request per phase; the bus engine's done retires the phase.
	logic issued;
	always_ff @(posedge REF_CLK) begin
		if (!RST_N)
			issued <= 1'b0;
		else if (CYC_DONE)
			issued <= 1'b0;
		else if (push)
			issued <= 1'b1;
	end
	assign push = !issued && !buf_v[1] &&
		state inside {ST_FETCH, ST_FETCH_HI, ST_DEPOSIT, ST_DEPOSIT_HI};

	// Two-entry buffer toward the engine so a stall loses no cycle.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			buf_v <= 2'h0;
			buf_d[0] <= '0;
			buf_d[1] <= '0;
		end else begin
			if (CYC_VALID && CYC_READY) begin
				buf_d[0] <= buf_v[1] ? buf_d[1] : push_d;
				buf_v <= {1'b0, buf_v[1] || push};
			end else if (push) begin
				if (buf_v[0]) begin
					buf_d[1] <= push_d;
					buf_v[1] <= 1'b1;
				end else begin
					buf_d[0] <= push_d;
					buf_v[0] <= 1'b1;
				end
			end
		end
	end

	assign CYC_VALID = buf_v[0];
	assign CYC = buf_d[0];
	// No acknowledge output exists; external logic may decode one.
	assign ARMED = {cfg[1].armed, cfg[0].armed};
	assign CH_BUSY = {state != ST_IDLE && ch, state != ST_IDLE && !ch};
	assign COUNTS = {cfg[1].count, cfg[0].count};

	default clocking dflt_cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	a_phase_order: assert property (
		state == ST_FETCH && CYC_DONE |=> state inside {ST_FETCH_HI,
		ST_DEPOSIT}) else $error("Fetch not followed by deposit.");
	a_no_switch: assert property (
		state != ST_IDLE && $past(state) != ST_IDLE |-> $stable(ch))
		else $error("Channel switched mid transfer.");
	a_count_step: assert property (
		state == ST_DONE && !LOAD[ch] |=>
		COUNTS[16*ch +: 16] == $past(COUNTS[16*ch +: 16]) - 16'h0001)
		else $error("Count did not drop.");
	a_req_delay: assert property (
		$rose(state == ST_FETCH) && cfg[ch].req_src == `TCDMA_SRC_PIN |->
		(ch ? $past(XFER_REQ[1], 4) : $past(XFER_REQ[0], 4)))
		else $error("Start too early.");
	a_armed_only: assert property (
		$rose(state == ST_FETCH) |-> (ch ? $past(cfg[1].armed) :
		$past(cfg[0].armed))) else $error("Disarmed channel started.");
	a_suspend_hold: assert property (
		$rose(state == ST_FETCH) |-> (ch ? !$past(SUSPEND[1]) :
		!$past(SUSPEND[0]))) else $error("Suspended channel started.");
	a_dest_idle: assert property (
		state == ST_DONE && cfg[ch].dest_sync |=> state == ST_IDLE [*3])
		else $error("Idle states missing.");
	a_odd_split: assert property (
		state == ST_FETCH && CYC_DONE && split && cfg[ch].src_ptr[0]
		|=> state == ST_FETCH_HI) else $error("Odd word not split.");
	a_dep_write: assert property (
		push && state == ST_DEPOSIT |-> push_d.write &&
		push_d.io == cfg[ch].dst_io) else $error("Bad deposit.");
	c_two_ch: cover property (@(posedge REF_CLK) want == 2'h3);
	c_odd: cover property (@(posedge REF_CLK) state == ST_DEPOSIT_HI);
	c_stall: cover property (@(posedge REF_CLK) CYC_VALID && !CYC_READY);
endmodule
